/* File: src/cwcs_config_word_clock_select.sv */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Codes 111/110/101 select external clock on input pin, high/medium/low power.
// - Code 100 selects internal oscillator and frees clock input pin for I/O.
// - Code 011 selects external RC network on the clock input pin.
// - Codes 010/001/000 drive crystal across both pins, high-speed/standard/low-power.
// - Fail-safe monitor enabled forces two-speed start-up regardless of switchover bit.
// - Brown-out reset never turns on the power-up timer by itself.
// - Code protection, once set, clears only through a bulk erase or a reset; the capture after reset reloads it.
module cwcs_config_word_clock_select
(
   input  wire logic                      I_CLK,          // System clock.
   input  wire logic                      I_RESETN,       // Async reset, active low.
   input  wire logic [cwcs_pkg::CFG_W-1:0] I_CFG_WORD,    // Nonvolatile configuration word.
   input  wire logic                      I_BULK_ERASE,   // Bulk erase pulse.
   output logic      [7:0]                O_CLK_SRC,      // One-hot clock source.
   output logic      [1:0]                O_POWER_LEVEL,  // Drive or clock power level.
   output logic                           O_CLOCK_INPUT_PIN_GPIO, // Clock input pin free for I/O.
   output logic                           O_OSC_DRIVE_EN, // Crystal amplifier on pin out.
   output logic                           O_FAIL_SAFE_EN, // Fail-safe clock monitor on.
   output logic                           O_TWO_SPEED_EN, // Two-speed start-up on.
   output logic                           O_BROWNOUT_EN,  // Brown-out reset on.
   output logic                           O_POWERUP_EN,   // Power-up timer on.
   output logic                           O_PROTECTED,    // Code protection active.
   output logic                           O_LOADED        // Settings captured.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Capture control. The word is taken on the first edge after reset release, since
   // an async reset may only load constants; until then every output is in its safe state.
   typedef enum logic [1:0]
   {
      LOAD_WAIT = 2'h1,
      LOAD_HOLD = 2'h2
   } cwcs_load_state_type;

   cwcs_load_state_type        load_q;
   cwcs_load_state_type        load_d;
   logic [cwcs_pkg::CFG_W-1:0] cfg_q;
   logic [cwcs_pkg::CFG_W-1:0] cfg_d;
   logic                       prot_q;
   logic                       prot_d;

   always_comb
   begin
      load_d = load_q;
      cfg_d  = cfg_q;
      prot_d = prot_q;
      unique case (load_q)
         LOAD_WAIT:
         begin
            // Capture wins over an erase seen on the same edge, so a part that leaves
            // reset protected cannot be opened by holding erase through the release.
            load_d = LOAD_HOLD;
            cfg_d  = I_CFG_WORD;
            prot_d = I_CFG_WORD[cwcs_pkg::PROTECT_BIT];
         end
         LOAD_HOLD:
         begin
            if (I_BULK_ERASE)
            begin
               prot_d = 1'h0;
            end
         end
         default:
         begin
            // An upset code keeps the held settings rather than reading the word
            // again, so a glitch can neither change the clock nor drop protection.
            load_d = LOAD_HOLD;
         end
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         load_q <= LOAD_WAIT;
         cfg_q  <= cwcs_pkg::CFG_RESET;
         prot_q <= cwcs_pkg::FLAG_RESET;
      end
      else
      begin
         load_q <= load_d;
         cfg_q  <= cfg_d;
         prot_q <= prot_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock source and pin use. The decode reads the next word, not the held one, so the
   // registered outputs already show the captured settings after the capture edge.
   logic [2:0] sel;
   logic [7:0] src_d;
   logic [7:0] src_q;
   logic [1:0] pwr_d;
   logic [1:0] pwr_q;
   logic       gpio_d;
   logic       gpio_q;
   logic       drv_d;
   logic       drv_q;

   assign sel = cfg_d[cwcs_pkg::OSC_SEL_LSB +: cwcs_pkg::OSC_SEL_W];

   // One source line per selection code, so exactly one is high for any code.
   for (genvar src_idx = 0; src_idx < 8; src_idx++)
   begin : g_src_bit
      assign src_d[src_idx] = (sel == 3'(src_idx));
   end

   always_comb
   begin
      pwr_d  = cwcs_pkg::PWR_LOW;
      gpio_d = 1'h0;
      drv_d  = 1'h0;
      unique case (sel)
         cwcs_pkg::SEL_EXT_CLOCK_HIGH_POWER:
         begin
            pwr_d = cwcs_pkg::PWR_HIGH;
         end
         cwcs_pkg::SEL_EXT_CLOCK_MEDIUM_POWER:
         begin
            pwr_d = cwcs_pkg::PWR_MEDIUM;
         end
         cwcs_pkg::SEL_EXT_CLOCK_LOW_POWER:
         begin
            pwr_d = cwcs_pkg::PWR_LOW;
         end
         cwcs_pkg::SEL_INTERNAL_OSCILLATOR:
         begin
            // No component sits on the clock input pin here, so it is handed to I/O.
            gpio_d = 1'h1;
         end
         cwcs_pkg::SEL_EXTERNAL_RC_MODE:
         begin
            // The network charges through the pin itself; the amplifier would fight it.
            pwr_d = cwcs_pkg::PWR_LOW;
         end
         cwcs_pkg::SEL_HIGH_SPEED_CRYSTAL:
         begin
            drv_d = 1'h1;
            pwr_d = cwcs_pkg::PWR_HIGH;
         end
         cwcs_pkg::SEL_STANDARD_CRYSTAL:
         begin
            drv_d = 1'h1;
            pwr_d = cwcs_pkg::PWR_MEDIUM;
         end
         cwcs_pkg::SEL_LOW_POWER_CRYSTAL:
         begin
            drv_d = 1'h1;
            pwr_d = cwcs_pkg::PWR_LOW;
         end
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         src_q  <= cwcs_pkg::SRC_RESET;
         pwr_q  <= cwcs_pkg::PWR_LOW;
         gpio_q <= cwcs_pkg::FLAG_RESET;
         drv_q  <= cwcs_pkg::FLAG_RESET;
      end
      else
      begin
         src_q  <= src_d;
         pwr_q  <= pwr_d;
         gpio_q <= gpio_d;
         drv_q  <= drv_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Start-up options. They are decoded from the same next word as the source, so
   // every clock and start-up output changes on the one capture edge and never in between.
   logic fsafe_d;
   logic fsafe_q;
   logic two_d;
   logic two_q;
   logic brown_d;
   logic brown_q;
   logic pwrup_d;
   logic pwrup_q;

   always_comb
   begin
      fsafe_d = cfg_d[cwcs_pkg::FAIL_SAFE_BIT];
      // The monitor must fall back to the internal clock at once if the chosen one
      // never starts, so it forces the two-speed start whatever the switchover bit says.
      two_d   = cfg_d[cwcs_pkg::SWITCH_BIT] | cfg_d[cwcs_pkg::FAIL_SAFE_BIT];
      brown_d = cfg_d[cwcs_pkg::BROWNOUT_BIT];
      // The timer follows its own bit only; brown-out is deliberately not ORed in.
      pwrup_d = cfg_d[cwcs_pkg::POWERUP_BIT];
   end

   always_ff @(posedge I_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         fsafe_q <= cwcs_pkg::FLAG_RESET;
         two_q   <= cwcs_pkg::FLAG_RESET;
         brown_q <= cwcs_pkg::FLAG_RESET;
         pwrup_q <= cwcs_pkg::FLAG_RESET;
      end
      else
      begin
         fsafe_q <= fsafe_d;
         two_q   <= two_d;
         brown_q <= brown_d;
         pwrup_q <= pwrup_d;
      end
   end

   assign O_CLK_SRC              = src_q;
   assign O_POWER_LEVEL          = pwr_q;
   assign O_CLOCK_INPUT_PIN_GPIO = gpio_q;
   assign O_OSC_DRIVE_EN         = drv_q;
   assign O_FAIL_SAFE_EN         = fsafe_q;
   assign O_TWO_SPEED_EN         = two_q;
   assign O_BROWNOUT_EN          = brown_q;
   assign O_POWERUP_EN           = pwrup_q;
   assign O_PROTECTED            = prot_q;
   // The hold bit of the one-hot code drives the flag straight from its flip-flop.
   assign O_LOADED               = load_q[1];

endmodule

/* File: src/cwcs_pkg.sv */
package cwcs_pkg;

   // Positions inside the configuration word.
   localparam int OSC_SEL_LSB   = 0;
   localparam int OSC_SEL_W     = 3;
   localparam int FAIL_SAFE_BIT = 3;
   localparam int SWITCH_BIT    = 4;
   localparam int BROWNOUT_BIT  = 5;
   localparam int POWERUP_BIT   = 6;
   localparam int PROTECT_BIT   = 7;
   localparam int CFG_W         = 8;

   // Oscillator selection codes.
   localparam logic [2:0] SEL_EXT_CLOCK_HIGH_POWER   = 3'h7;
   localparam logic [2:0] SEL_EXT_CLOCK_MEDIUM_POWER = 3'h6;
   localparam logic [2:0] SEL_EXT_CLOCK_LOW_POWER    = 3'h5;
   localparam logic [2:0] SEL_INTERNAL_OSCILLATOR    = 3'h4;
   localparam logic [2:0] SEL_EXTERNAL_RC_MODE       = 3'h3;
   localparam logic [2:0] SEL_HIGH_SPEED_CRYSTAL     = 3'h2;
   localparam logic [2:0] SEL_STANDARD_CRYSTAL       = 3'h1;
   localparam logic [2:0] SEL_LOW_POWER_CRYSTAL      = 3'h0;

   // One-hot clock source, one bit per mode.
   localparam logic [7:0] SRC_RESET = 8'h00;

   // Power level codes for external clock and crystal drive.
   localparam logic [1:0] PWR_LOW    = 2'h0;
   localparam logic [1:0] PWR_MEDIUM = 2'h1;
   localparam logic [1:0] PWR_HIGH   = 2'h2;

   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

   // Reset value of every single-bit flag.
   localparam logic FLAG_RESET = 1'h0;

endpackage

/* File: tb/cwcs_chk.sv */
`timescale 1ns/1ns
module cwcs_chk
(
   input wire logic                        I_CLK,
   input wire logic                        I_RESETN,
   input wire logic [cwcs_pkg::CFG_W-1:0] I_CFG_WORD,
   input wire logic                        I_BULK_ERASE,
   input wire logic [7:0]                  O_CLK_SRC,
   input wire logic                        O_CLOCK_INPUT_PIN_GPIO,
   input wire logic                        O_OSC_DRIVE_EN,
   input wire logic                        O_TWO_SPEED_EN,
   input wire logic                        O_POWERUP_EN,
   input wire logic                        O_PROTECTED,
   input wire logic                        O_LOADED
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);
   src_decode_a: assert property ($rose(O_LOADED) |->
      O_CLK_SRC == 8'h01 << $past(I_CFG_WORD[2:0])) else $error("bad source");
   gpio_pin_a: assert property ($rose(O_LOADED) |->
      O_CLOCK_INPUT_PIN_GPIO == ($past(I_CFG_WORD[2:0]) == 3'h4)) else $error("bad gpio");
   drive_en_a: assert property ($rose(O_LOADED) |->
      O_OSC_DRIVE_EN == ($past(I_CFG_WORD[2:0]) < 3'h3)) else $error("bad drive");
   two_speed_a: assert property ($rose(O_LOADED) |->
      O_TWO_SPEED_EN == |$past(I_CFG_WORD[4:3])) else $error("bad two-speed");
   powerup_a: assert property ($rose(O_LOADED) |->
      O_POWERUP_EN == $past(I_CFG_WORD[6])) else $error("bad power-up");
   hold_a: assert property (O_LOADED |=> $stable(O_CLK_SRC)) else $error("moved");
   erase_clr_a: assert property (O_LOADED && I_BULK_ERASE |=> !O_PROTECTED)
      else $error("no clear");
   protect_hold_a: assert property (O_PROTECTED && !I_BULK_ERASE |=> O_PROTECTED)
      else $error("lost protect");
   capture_win_a: assert property ($rose(O_LOADED) |->
      O_PROTECTED == $past(I_CFG_WORD[7])) else $error("bad protect capture");
endmodule

/* File: tb/cwcs_config_word_clock_select_bench.sv */
`timescale 1ns/1ns
module cwcs_config_word_clock_select_bench;
   logic       clk = 1'h0;
   logic       rst_n = 1'h0;
   logic [7:0] word = 8'h00;
   logic       erase = 1'h0;
   logic [7:0] src;
   logic [1:0] lvl;
   logic       gpio, drv, fs, two, bo, pu, prot, ld, osc_ok;
   int         n_fail = 0;
   int         comparisons = 0;
   initial forever #5 clk = ~clk;
   cwcs_config_word_clock_select cwcs_config_word_clock_select_inst (.I_CLK(clk),
      .I_RESETN(rst_n), .I_CFG_WORD(word), .I_BULK_ERASE(erase), .O_CLK_SRC(src),
      .O_POWER_LEVEL(lvl), .O_CLOCK_INPUT_PIN_GPIO(gpio), .O_OSC_DRIVE_EN(drv),
      .O_FAIL_SAFE_EN(fs), .O_TWO_SPEED_EN(two), .O_BROWNOUT_EN(bo), .O_POWERUP_EN(pu),
      .O_PROTECTED(prot), .O_LOADED(ld));
   cwcs_osc_model cwcs_osc_model_inst (.i_drive_en(drv), .o_osc_ok(osc_ok));
   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // The word is flipped right after capture, so the src, fsafe, brown, pwrup and prot checks also prove it was ignored.
   // An erase given with the release is seen on the capture edge only, where capture wins.
   task load(input logic [7:0] w, input logic e);
      @(posedge clk) rst_n <= 1'h0;
      word <= w;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      erase <= e;
      @(posedge clk) word <= ~w;
      erase <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      n_fail++;
      results;
   end
   initial
   begin
      for (logic [7:0] k = 8'h00; k < 8'h80; k++)
      begin
         load(k, 1'h0);
         chk("src", src, 8'h01 << k[2:0]);
         chk("gpio", gpio, k[2:0] == 3'h4);
         chk("osc", osc_ok, k[2:0] < 3'h3);
         chk("level", lvl, k[2:0] > 3'h4 ? k[2:0] - 3'h5 : (k[2:0] < 3'h3 ? k[2:0] : 3'h0));
         chk("fsafe", fs, k[3]);
         chk("two", two, k[3] | k[4]);
         chk("brown", bo, k[5]);
         chk("pwrup", pu, k[6]);
         chk("prot", prot, 8'h00);
         chk("loaded", ld, 8'h01);
      end
      $display("decode test done");
      load(8'h80, 1'h0);
      chk("prot", prot, 8'h01);
      @(posedge clk) erase <= 1'h1;
      @(posedge clk) erase <= 1'h0;
      repeat (2) @(posedge clk);
      #1 chk("erase", prot, 8'h00);
      load(8'h80, 1'h1);
      chk("capture", prot, 8'h01);
      $display("protect test done");
      results;
   end
endmodule
bind cwcs_config_word_clock_select cwcs_chk cwcs_chk_inst (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
   .I_CFG_WORD(I_CFG_WORD), .I_BULK_ERASE(I_BULK_ERASE), .O_CLK_SRC(O_CLK_SRC),
   .O_CLOCK_INPUT_PIN_GPIO(O_CLOCK_INPUT_PIN_GPIO), .O_OSC_DRIVE_EN(O_OSC_DRIVE_EN),
   .O_TWO_SPEED_EN(O_TWO_SPEED_EN), .O_POWERUP_EN(O_POWERUP_EN),
   .O_PROTECTED(O_PROTECTED), .O_LOADED(O_LOADED));

/* File: tb/cwcs_osc_model.sv */
`timescale 1ns/1ns
module cwcs_osc_model
(
   input  wire logic i_drive_en, // Amplifier drive on the output pin.
   output logic      o_osc_ok    // Crystal is swinging.
);
   // An undriven crystal never starts, so no drive means no clock at all.
   assign o_osc_ok = i_drive_en;
endmodule
